// >>> pkg/fetch_ctl_pkg.sv
// constants, encodings and shared types for the fetch and branch control
// assumes a single core clock; every timing figure here is in core cycles
package fetch_ctl_pkg;

	// address and cache geometry
	localparam int VPN_W = 28; // virtual page number, 8 KB pages
	localparam int PPN_W = 28; // physical page number
	localparam int LINE_W = 8; // i-cache set index
	localparam int WAY_W = 1; // i-cache way number
	localparam int PAIR_W = 10; // one prediction entry per two instructions
	localparam int GROUP_W = 9; // one next field per four instructions
	localparam int NEXT_W = LINE_W + WAY_W; // next field width
	localparam int ITT_ENTRIES = 64; // instruction translation table size
	localparam int ITT_IDX_W = 6; // index into the table

	// page sizes, coded as low vpn bits to ignore
	localparam logic [1:0] PG_8K = 2'h0;
	localparam logic [1:0] PG_64K = 2'h1;
	localparam logic [1:0] PG_512K = 2'h2;
	localparam logic [1:0] PG_4M = 2'h3;
	localparam int PG_STEP_BITS = 3; // each size step is eight times larger

	// timing counts in core cycles, then prefetch width and buffer sizes
	localparam logic [2:0] MISPRED_CYCLES = 3'h4; // mispredict penalty
	localparam logic [3:0] COUPLE_CYCLES = 4'h9; // false trap on a couple
	localparam logic [3:0] COUPLE_SQUASH_AT = 4'h1; // second one in N3
	localparam logic [2:0] ICMISS_CYCLES = 3'h6; // e-cache hit refill
	localparam logic [1:0] TAKEN_INIT_LOST = 2'h2; // stale next field
	localparam logic [2:0] FETCH_WIDTH = 3'h4; // prefetch per cycle
	localparam int BUF_DEPTH = 12; // instruction buffer slots
	localparam int BUF_CNT_W = 5; // occupancy counter width

	// predictor states, msb is the predicted direction
	typedef enum logic [1:0] {
		PR_STRONG_NOT = 2'h0,
		PR_LIKELY_NOT = 2'h1,
		PR_LIKELY_TAKEN = 2'h2,
		PR_STRONG_TAKEN = 2'h3
	} pred_type;

	// instruction classes seen by grouping
	typedef enum logic [2:0] {
		K_OTHER = 3'h0,
		K_SETCC = 3'h1,
		K_CBR = 3'h2,
		K_MOVCC = 3'h3,
		K_COND_MOVE_ON_REGISTER = 3'h4,
		K_FLOAT_COND_MOVE_ON_REGISTER = 3'h5,
		K_IEU = 3'h6,
		K_FPOP = 3'h7
	} kind_type;

	// translation table entry
	typedef struct packed {
		logic valid;
		logic [1:0] size;
		logic [VPN_W-1:0] vpn;
		logic [PPN_W-1:0] ppn;
	} itt_entry_type;

endpackage : fetch_ctl_pkg

// >>> sim/c_stage_model.sv
// behavioural pipeline from fetch to the C stage, for branch resolve
// assumes go is a one-cycle pulse from the bench with the fetch state
`timescale 1ns/10ps
module c_stage_model
	import fetch_ctl_pkg::*;
(
	input wire logic clk, // core clock
	input wire logic rst_n, // async reset, active low
	input wire logic go, // branch leaves fetch
	input wire logic goTaken, // its real outcome
	input wire logic [1:0] goState, // state seen at fetch
	input wire logic [PAIR_W-1:0] goPair, // its pair entry
	output logic resolveValid, // pulse in the C stage
	output logic resolveTaken, // outcome
	output logic [1:0] resolvePredState, // carried state
	output logic [PAIR_W-1:0] resolvePairIdx // carried pair
);
	logic [2:0] age; // stages still to travel
	logic hTaken; // held outcome
	logic [1:0] hState; // held state
	logic [PAIR_W-1:0] hPair; // held pair

	// resolve always in C, whatever precedes it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			age <= 3'h0;
			resolveValid <= 1'b0;
			{resolveTaken, resolvePredState, resolvePairIdx} <= '0;
			{hTaken, hState, hPair} <= '0;
		end else begin
			resolveValid <= (age == 3'h1);
			if (go) begin
				age <= 3'h3;
				{hTaken, hState, hPair} <= {goTaken, goState, goPair};
			end else if (age != 3'h0) begin
				age <= age - 3'h1;
			end
			// idle data toggles so a stale value is never trusted
			if (age == 3'h1) begin
				{resolveTaken, resolvePredState, resolvePairIdx} <=
					{hTaken, hState, hPair};
			end else begin
				{resolveTaken, resolvePredState, resolvePairIdx} <=
					~{resolveTaken, resolvePredState, resolvePairIdx};
			end
		end
	end
endmodule : c_stage_model

// >>> sim/fetch_branch_predict_control_checker.sv
// port-level checks on the fetch and branch control block
// assumes one core clock and the async active-low reset of the top
`timescale 1ns/10ps
module fetch_branch_predict_control_checker
	import fetch_ctl_pkg::*;
(
	input wire logic clk, // core clock
	input wire logic rst_n, // async reset, active low
	input wire logic fetchReady, // table walk idle
	input wire logic xlatValid, // translation pulse
	input wire logic ittMissTrap, // trap pulse
	input wire logic resolveValid, // resolve pulse
	input wire logic [1:0] resolvePredState, // state seen at fetch
	input wire logic resolveTaken, // actual outcome
	input wire logic mispredict, // penalty level
	input wire logic nextFieldStale, // next field not usable
	input wire logic coupleDetect, // couple seen
	input wire logic falseTrapBusy, // couple being handled
	input wire logic squashRestart, // squash pulse
	input wire logic icRefillBusy, // refill level
	input wire logic fillReady, // buffer takes a fetch
	input wire logic [BUF_CNT_W-1:0] bufCount, // occupancy
	input wire logic [3:0] slotValid, // candidates
	input wire logic [3:0][2:0] slotKind, // candidate classes
	input wire logic [2:0] issueCount // issued this cycle
);
	// single domain, so one default clock and disable
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// a page change costs exactly one walk cycle
	a_walk_cost: assert property ($fell(fetchReady) |=>
		(fetchReady && xlatValid) || (!fetchReady && ittMissTrap))
		else $error("walk not one cycle");
	a_trap_once: assert property (ittMissTrap |=>
		!ittMissTrap && !xlatValid)
		else $error("bad trap pulse");
	a_stale_span: assert property ($rose(nextFieldStale) |->
		nextFieldStale[*2] ##1 !nextFieldStale)
		else $error("stale not two cycles");
	// penalty only follows a resolve whose direction disagrees
	a_miss_cause: assert property ($rose(mispredict) |->
		$past(resolveValid) &&
		($past(resolvePredState[1]) != $past(resolveTaken)))
		else $error("penalty without cause");
	a_miss_span: assert property ($rose(mispredict) |->
		mispredict[*4] ##1 !mispredict)
		else $error("penalty not four cycles");
	a_hold_issue: assert property ((mispredict || falseTrapBusy) |->
		issueCount == 3'h0)
		else $error("issue during a penalty");
	a_couple_go: assert property ((coupleDetect && !falseTrapBusy) |=>
		falseTrapBusy)
		else $error("couple not taken up");
	a_couple_span: assert property ($rose(falseTrapBusy) |->
		(falseTrapBusy && !squashRestart)[*8] ##1
		(falseTrapBusy && !squashRestart) ##1
		(!falseTrapBusy && squashRestart))
		else $error("couple not nine cycles");
	a_refill_span: assert property ($rose(icRefillBusy) |->
		icRefillBusy[*6] ##1 !icRefillBusy)
		else $error("refill not six cycles");
	a_fill_gate: assert property ((icRefillBusy || bufCount > 5'h8) |->
		!fillReady)
		else $error("fill offered while blocked");
	a_lone_move: assert property ((slotValid[0] &&
		slotKind[0] inside {K_MOVCC, K_COND_MOVE_ON_REGISTER}) |-> issueCount <= 3'h1)
		else $error("move grouped");

	// main scenarios reached
	c_mispred: cover property ($rose(mispredict));
	c_couple: cover property (squashRestart);
	c_trap: cover property (ittMissTrap);
endmodule : fetch_branch_predict_control_checker

bind fetch_branch_predict_control fetch_branch_predict_control_checker chk (
	.clk, .rst_n, .fetchReady, .xlatValid, .ittMissTrap, .resolveValid,
	.resolvePredState, .resolveTaken, .mispredict, .nextFieldStale,
	.coupleDetect, .falseTrapBusy, .squashRestart, .icRefillBusy,
	.fillReady, .bufCount, .slotValid, .slotKind, .issueCount);

// >>> sim/fetch_branch_predict_control_tb.sv
// self-checking bench for the fetch and branch control block
// assumes the checker is bound in and the C stage model supplies resolve
`timescale 1ns/10ps
module fetch_branch_predict_control_tb
	import fetch_ctl_pkg::*;
;
	logic clk, rst_n, fetchValid, refillValid; // clock, reset, requests
	logic [VPN_W-1:0] fetchVpn, refillVpn; // pages
	logic [PPN_W-1:0] xlatPpn, refillPpn; // physical pages
	logic [ITT_IDX_W-1:0] refillIdx; // table slot
	logic [1:0] refillSize, predState, resolvePredState; // codes
	logic fetchReady, xlatValid, ittMissTrap; // translation results
	logic [PAIR_W-1:0] fetchPairIdx, brPairIdx, resolvePairIdx; // pairs
	logic predTaken, nextFieldStale, brInit, brHinted, brHintTaken;
	logic [LINE_W-1:0] nextLine; // next field line
	logic [WAY_W-1:0] nextWay; // next field way
	logic resolveValid, resolveTaken, mispredict, brGo, brTaken;
	logic [2:0] fillCount, issueCount; // buffer traffic
	logic fillReady, icMissHit, icRefillBusy, loadBufEmpty;
	logic [BUF_CNT_W-1:0] bufCount; // occupancy
	logic [3:0] slotValid, slotUsesMovDst; // grouping candidates
	logic [3:0][2:0] slotKind; // candidate classes
	logic coupleDetect, falseTrapBusy, squashRestart; // couple
	int n_errors, check_count; // tallies

	// 100 MHz core clock
	always #5 clk = ~clk;

	fetch_branch_predict_control DUT (.*,
		.fetchGroupIdx(fetchPairIdx[9:1]),
		.resolveGroupIdx(resolvePairIdx[9:1]),
		.resolveTargetLine(8'h3C), .resolveTargetWay(1'b1),
		.resolveSeqLine(8'h11), .resolveSeqWay(1'b0));

	c_stage_model PIPE (.clk, .rst_n, .go(brGo), .goTaken(brTaken),
		.goState(predState), .goPair(fetchPairIdx), .resolveValid,
		.resolveTaken, .resolvePredState, .resolvePairIdx);

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	// one value compare, four-state exact
	task automatic chk(input string w, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s exp %0h got %0h", w, e, g);
		end
	endtask : chk

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : print_verdict

	task automatic refill(input logic [5:0] i, input logic [27:0] v, p,
		input logic [1:0] s);
		{refillIdx, refillVpn, refillPpn, refillSize} = {i, v, p, s};
		refillValid = 1'b1;
		cyc(1);
		refillValid = 1'b0;
	endtask : refill

	// lat 1 on a buffer hit, 2 through the table
	task automatic xlat(input logic [27:0] v, input int lat, input logic t);
		{fetchVpn, fetchValid} = {v, 1'b1};
		cyc(1);
		fetchValid = 1'b0;
		cyc(lat - 1);
		chk("xlat or trap", 32'h1, 32'(t ? ittMissTrap : xlatValid));
		cyc(1);
	endtask : xlat

	task automatic t_xlat();
		refill(6'h0, 28'h10, 28'h55, PG_8K);
		xlat(28'h10, 2, 1'b0);
		chk("ppn", 32'h55, 32'(xlatPpn));
		xlat(28'h10, 1, 1'b0);
		xlat(28'h20, 2, 1'b1);
		refill(6'h3F, 28'h1000, 28'h66, PG_4M);
		xlat(28'h11FF, 2, 1'b0);
		$display("test xlat done");
	endtask : t_xlat

	task automatic init(input logic [9:0] p, input logic h, t,
		input logic [1:0] e);
		{fetchPairIdx, brPairIdx, brHinted, brHintTaken} = {p, p, h, t};
		brInit = 1'b1;
		cyc(1);
		brInit = 1'b0;
		cyc(1);
		chk("init state", 32'(e), 32'(predState));
		chk("stale", 32'(h & t), 32'(nextFieldStale));
	endtask : init

	// resolve through the C stage model, count penalty cycles
	task automatic resolve(input logic tk, input int en,
		input logic [1:0] es);
		int n = 0;
		brTaken = tk;
		brGo = 1'b1;
		cyc(1);
		brGo = 1'b0;
		repeat (12) begin
			cyc(1);
			if (mispredict === 1'b1) n++;
		end
		chk("penalty", 32'(en), 32'(n));
		chk("next state", 32'(es), 32'(predState));
		chk("next field", tk ? 32'h79 : 32'h22,
			32'({nextLine, nextWay}));
	endtask : resolve

	task automatic t_pred();
		init(10'h6, 1'b0, 1'b1, PR_LIKELY_NOT);
		init(10'h7, 1'b1, 1'b0, PR_LIKELY_NOT);
		init(10'h5, 1'b1, 1'b1, PR_LIKELY_TAKEN);
		resolve(1'b1, 0, PR_STRONG_TAKEN);
		resolve(1'b0, 4, PR_LIKELY_TAKEN);
		chk("still taken", 32'h1, 32'(predTaken));
		resolve(1'b0, 4, PR_LIKELY_NOT);
		resolve(1'b0, 0, PR_STRONG_NOT);
		resolve(1'b0, 0, PR_STRONG_NOT);
		$display("test pred done");
	endtask : t_pred

	// count how long the couple handling and refill levels stand
	task automatic t_timers();
		int b = 0, s = 0, r = 0;
		coupleDetect = 1'b1;
		icMissHit = 1'b1;
		cyc(1);
		{coupleDetect, icMissHit} = 2'h0;
		chk("fill during refill", 32'h0, 32'(fillReady));
		repeat (14) begin
			b += (falseTrapBusy === 1'b1);
			s += (squashRestart === 1'b1);
			r += (icRefillBusy === 1'b1);
			cyc(1);
		end
		chk("couple cycles", 32'h9, 32'(b));
		chk("squash pulses", 32'h1, 32'(s));
		chk("refill cycles", 32'h6, 32'(r));
		$display("test timers done");
	endtask : t_timers

	task automatic t_fill();
		fillCount = 3'h4;
		cyc(1);
		chk("buffered", 32'h4, 32'(bufCount));
		cyc(3);
		chk("full refuses", 32'h0, 32'(fillReady));
		chk("buffered max", 32'hC, 32'(bufCount));
		fillCount = 3'h0;
		$display("test fill done");
	endtask : t_fill

	task automatic grp(input logic [3:0] v, input kind_type k0, k1, k2,
		input logic u, l, input logic [2:0] e);
		{slotValid, slotKind} = {v, K_OTHER, k2, k1, k0};
		{slotUsesMovDst, loadBufEmpty} = {3'h0, u, l};
		#1;
		chk("issue count", 32'(e), 32'(issueCount));
		cyc(1);
	endtask : grp

	task automatic t_group();
		grp(4'h7, K_SETCC, K_CBR, K_OTHER, 0, 1, 3'h3);
		grp(4'hF, K_MOVCC, K_OTHER, K_OTHER, 0, 1, 3'h1);
		grp(4'h1, K_OTHER, K_OTHER, K_OTHER, 1, 1, 3'h0);
		grp(4'hF, K_COND_MOVE_ON_REGISTER, K_OTHER, K_OTHER, 0, 1, 3'h1);
		grp(4'h1, K_OTHER, K_OTHER, K_OTHER, 1, 1, 3'h0);
		grp(4'h7, K_OTHER, K_OTHER, K_MOVCC, 0, 1, 3'h2);
		grp(4'h1, K_FLOAT_COND_MOVE_ON_REGISTER, K_OTHER, K_OTHER, 0, 0, 3'h0);
		grp(4'h1, K_FLOAT_COND_MOVE_ON_REGISTER, K_OTHER, K_OTHER, 0, 1, 3'h1);
		grp(4'h1, K_IEU, K_OTHER, K_OTHER, 0, 1, 3'h0);
		slotValid = 4'h0;
		$display("test group done");
	endtask : t_group

	// main sequence, every input valued at time zero
	initial begin
		{clk, rst_n, fetchValid, refillValid, brInit, brGo} = 6'h0;
		{fetchVpn, refillVpn, refillPpn, refillIdx, refillSize} = '0;
		{fetchPairIdx, brPairIdx, brHinted, brHintTaken, brTaken} = '0;
		{fillCount, icMissHit, coupleDetect} = '0;
		{slotValid, slotKind, slotUsesMovDst} = '0;
		loadBufEmpty = 1'b1;
		{n_errors, check_count} = '0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		t_xlat();
		t_pred();
		t_fill();
		t_timers();
		t_group();
		print_verdict();
	end

	// 5000 cycles, far beyond a clean run
	initial begin
		#50000;
		n_errors++;
		print_verdict();
	end
endmodule : fetch_branch_predict_control_tb

// >>> verilog/fetch_branch_predict_control.sv
// fetch translation, branch prediction, mispredict and grouping control
// assumes the i-cache, e-cache and pipeline run on this same clock and
// that resolution arrives from the C stage with the state seen at fetch
`timescale 1ns/10ps

// Contract
// - one-entry micro buffer forwards same-page lines
// - page change looks up table, one cycle
// - translation table: 64 entries, pages to 4MB
// - table miss traps to software refill
// - hint bit initialises entry likely taken/not
// - unhinted branches initialise likely not taken
// - likely-taken init loses two fetch cycles
// - two mispredicts flip steady taken prediction
// - conditional branches resolve in C stage
// - mispredicted branch costs four cycles
// - setcc, branch, delay slot share group
// - conditional moves issue as lone groups
// - move result use breaks group, one bubble
// - float register move waits empty load buffer
// - one group between float move, younger integer
// - couple: run to N3, squash, restart second
// - couple false trap costs nine cycles
// - prefetch fills four instructions per cycle
// - e-cache hit refill takes six cycles
// - two-bit prediction per instruction pair
// - next field per four instructions
module fetch_branch_predict_control
	import fetch_ctl_pkg::*;
(
	input wire logic clk, // core clock
	input wire logic rst_n, // async reset, active low
	// fetch translation
	input wire logic fetchValid, // a line fetch is presented
	input wire logic [VPN_W-1:0] fetchVpn, // its virtual page
	output logic fetchReady, // translation accepts a fetch
	output logic xlatValid, // one-cycle pulse, translation done
	output logic [PPN_W-1:0] xlatPpn, // physical page for the fetch
	output logic ittMissTrap, // one-cycle pulse, trap to software
	input wire logic refillValid, // software writes a table entry
	input wire logic [ITT_IDX_W-1:0] refillIdx, // entry to write
	input wire logic [VPN_W-1:0] refillVpn, // entry virtual page
	input wire logic [PPN_W-1:0] refillPpn, // entry physical page
	input wire logic [1:0] refillSize, // entry page size
	// prediction lookup and initialisation
	input wire logic [PAIR_W-1:0] fetchPairIdx, // pair being fetched
	input wire logic [GROUP_W-1:0] fetchGroupIdx, // group being fetched
	output logic predTaken, // prediction for last fetched pair
	output logic [1:0] predState, // full state, carried to C stage
	output logic [LINE_W-1:0] nextLine, // next field, line index
	output logic [WAY_W-1:0] nextWay, // next field, way
	output logic nextFieldStale, // next field not usable yet
	input wire logic brInit, // pulse, first sight of a branch
	input wire logic [PAIR_W-1:0] brPairIdx, // its pair entry
	input wire logic brHinted, // opcode carries a static hint
	input wire logic brHintTaken, // the static hint bit
	// resolution from the C stage
	input wire logic resolveValid, // pulse, branch resolved
	input wire logic [PAIR_W-1:0] resolvePairIdx, // its pair entry
	input wire logic [GROUP_W-1:0] resolveGroupIdx, // its group
	input wire logic [1:0] resolvePredState, // state used at fetch
	input wire logic resolveTaken, // actual outcome
	input wire logic [LINE_W-1:0] resolveTargetLine, // taken target
	input wire logic [WAY_W-1:0] resolveTargetWay, // taken target way
	input wire logic [LINE_W-1:0] resolveSeqLine, // sequential line
	input wire logic [WAY_W-1:0] resolveSeqWay, // sequential way
	output logic mispredict, // level, penalty cycles running
	// prefetch and instruction buffer
	input wire logic [2:0] fillCount, // instructions fetched this cycle
	output logic fillReady, // buffer can take a full fetch
	input wire logic icMissHit, // pulse, i-cache miss hit e-cache
	output logic icRefillBusy, // level, refill in progress
	output logic [BUF_CNT_W-1:0] bufCount, // instructions buffered
	// grouping
	input wire logic [3:0] slotValid, // buffered candidates
	input wire logic [3:0][2:0] slotKind, // class of each candidate
	input wire logic [3:0] slotUsesMovDst, // reads a cond move result
	input wire logic loadBufEmpty, // load buffer has drained
	output logic [2:0] issueCount, // instructions issued this cycle
	// back-to-back control transfers
	input wire logic coupleDetect, // pulse, second of a couple seen
	output logic falseTrapBusy, // level, couple being handled
	output logic squashRestart // pulse, squash and restart at second
);

	// translation walk states
	typedef enum logic [1:0] {
		T_IDLE = 2'h0,
		T_LOOKUP = 2'h1,
		T_TRAP = 2'h2
	} tstate_type;

	// all state of the block outside the two pred_ram instances
	typedef struct packed {
		tstate_type tState; // translation walk
		logic utbValid; // micro buffer holds an entry
		logic [VPN_W-1:0] utbVpn; // its virtual page
		logic [PPN_W-1:0] utbPpn; // its physical page
		logic [VPN_W-1:0] pendVpn; // page waiting for the table
		itt_entry_type [ITT_ENTRIES-1:0] itt; // translation table
		logic xlatValid; // translation pulse
		logic [PPN_W-1:0] xlatPpn; // translation result
		logic missTrap; // trap pulse
		logic [2:0] penaltyCnt; // mispredict penalty left
		logic [1:0] lostCnt; // stale next field cycles left
		logic [3:0] coupleCnt; // false trap cycles left
		logic squash; // squash pulse
		logic [2:0] icMissCnt; // refill cycles left
		logic [BUF_CNT_W-1:0] bufCount; // buffer occupancy
		logic movPend; // last group was an integer cond move
		logic fmovSep; // last group was a float register move
	} state_type;

	state_type s_r; // registered state
	state_type s_nxt; // next state

	logic [1:0] predRd; // predictor read data
	logic [NEXT_W-1:0] nextRd; // next field read data
	logic [1:0] stepNxt; // predictor state after resolution
	logic predWe; // predictor write strobe
	logic [PAIR_W-1:0] predWAddr; // predictor write address
	logic [1:0] predWData; // predictor write data
	logic [NEXT_W-1:0] nextWData; // next field write data
	logic ittHit; // table lookup found the page
	logic [PPN_W-1:0] ittPpn; // physical page from the table
	logic [2:0] grpN; // group size chosen this cycle
	logic grpLoneMov; // the group is one integer cond move
	logic grpFmov; // the group is one float register move
	logic stopScan; // grouping cut found

	// per-pair prediction storage, registered read
	pred_ram #(.W(2), .A(PAIR_W)) u_pred (
		.clk(clk),
		.rst_n(rst_n),
		.we(predWe),
		.wAddr(predWAddr),
		.wData(predWData),
		.rAddr(fetchPairIdx),
		.rData(predRd)
	);

	// per-group next field storage, registered read
	pred_ram #(.W(NEXT_W), .A(GROUP_W)) u_next (
		.clk(clk),
		.rst_n(rst_n),
		.we(resolveValid),
		.wAddr(resolveGroupIdx),
		.wData(nextWData),
		.rAddr(fetchGroupIdx),
		.rData(nextRd)
	);

	// saturating update of the resolved entry
	pred_step u_step (
		.cur(resolvePredState),
		.taken(resolveTaken),
		.nxt(stepNxt)
	);

	// predictor writes: resolution wins over a same-cycle initialisation,
	// the lost initialisation only costs a cold entry
	always_comb begin
		predWe = resolveValid | brInit;
		predWAddr = brPairIdx;
		predWData = PR_LIKELY_NOT;
		if (resolveValid) begin
			predWAddr = resolvePairIdx;
			predWData = stepNxt;
		end else if (brHinted && brHintTaken) begin
			predWData = PR_LIKELY_TAKEN;
		end else if (brHinted) begin
			predWData = PR_LIKELY_NOT;
		end
		// taken target, or the sequential line by default
		if (resolveTaken) begin
			nextWData = {resolveTargetLine, resolveTargetWay};
		end else begin
			nextWData = {resolveSeqLine, resolveSeqWay};
		end
	end

	// fully associative table search, larger pages ignore low vpn bits
	always_comb begin
		logic [VPN_W-1:0] mask;
		mask = '0;
		ittHit = 1'b0;
		ittPpn = '0;
		for (int i = 0; i < ITT_ENTRIES; i++) begin
			mask = ~((VPN_W'(1) << (s_r.itt[i].size * PG_STEP_BITS))
				- VPN_W'(1));
			if (s_r.itt[i].valid && !ittHit &&
				((s_r.itt[i].vpn & mask) == (s_r.pendVpn & mask))) begin
				ittHit = 1'b1;
				ittPpn = (s_r.itt[i].ppn & mask) | (s_r.pendVpn & ~mask);
			end
		end
	end

	// group formation; setcc, branch and delay slot never cut a group
	always_comb begin
		grpN = 3'h0;
		stopScan = 1'b0;
		grpLoneMov = 1'b0;
		grpFmov = 1'b0;
		if (s_r.penaltyCnt != 3'h0 || s_r.coupleCnt != 4'h0) begin
			stopScan = 1'b1; // pipeline being redirected
		end else if (s_r.fmovSep) begin
			stopScan = 1'b1;
		end else if (s_r.movPend && slotUsesMovDst[0]) begin
			stopScan = 1'b1;
		end
		for (int i = 0; i < 4; i++) begin
			if (!stopScan && slotValid[i]) begin
				if (slotKind[i] == K_MOVCC || slotKind[i] == K_COND_MOVE_ON_REGISTER) begin
					stopScan = 1'b1;
					if (i == 0) begin
						grpN = 3'h1;
						grpLoneMov = 1'b1;
					end
				end else if (slotKind[i] == K_FLOAT_COND_MOVE_ON_REGISTER) begin
					stopScan = 1'b1;
					if (i == 0 && loadBufEmpty) begin
						grpN = 3'h1;
						grpFmov = 1'b1;
					end
				end else begin
					grpN = 3'(i + 1);
				end
			end else begin
				stopScan = 1'b1;
			end
		end
	end

	// next state of everything else
	always_comb begin
		s_nxt = s_r;
		s_nxt.xlatValid = 1'b0;
		s_nxt.missTrap = 1'b0;
		s_nxt.squash = 1'b0;

		// software refill of the table, any time
		if (refillValid) begin
			s_nxt.itt[refillIdx].valid = 1'b1;
			s_nxt.itt[refillIdx].size = refillSize;
			s_nxt.itt[refillIdx].vpn = refillVpn;
			s_nxt.itt[refillIdx].ppn = refillPpn;
		end

		// translation walk
		unique case (s_r.tState)
			T_IDLE: begin
				if (fetchValid && s_r.utbValid && fetchVpn == s_r.utbVpn) begin
					s_nxt.xlatValid = 1'b1;
					s_nxt.xlatPpn = s_r.utbPpn;
				end else if (fetchValid) begin
					s_nxt.pendVpn = fetchVpn;
					s_nxt.tState = T_LOOKUP;
				end
			end
			T_LOOKUP: begin
				if (ittHit) begin
					s_nxt.xlatValid = 1'b1;
					s_nxt.xlatPpn = ittPpn;
					s_nxt.utbValid = 1'b1;
					s_nxt.utbVpn = s_r.pendVpn;
					s_nxt.utbPpn = ittPpn;
					s_nxt.tState = T_IDLE;
				end else begin
					s_nxt.missTrap = 1'b1;
					s_nxt.tState = T_TRAP;
				end
			end
			T_TRAP: begin
				// the handler refills and then refetches the line
				if (refillValid) begin
					s_nxt.tState = T_IDLE;
				end
			end
			default: begin
				s_nxt.tState = T_IDLE;
			end
		endcase
		// a refill may replace the page the micro buffer copies
		if (refillValid) begin
			s_nxt.utbValid = 1'b0;
		end

		// stale next field after a likely-taken initialisation
		if (s_r.lostCnt != 2'h0) begin
			s_nxt.lostCnt = s_r.lostCnt - 2'h1;
		end
		if (brInit && !resolveValid && brHinted && brHintTaken) begin
			s_nxt.lostCnt = TAKEN_INIT_LOST;
		end

		// mispredict penalty, a new one restarts the count
		if (s_r.penaltyCnt != 3'h0) begin
			s_nxt.penaltyCnt = s_r.penaltyCnt - 3'h1;
		end
		if (resolveValid && resolvePredState[1] != resolveTaken) begin
			s_nxt.penaltyCnt = MISPRED_CYCLES;
		end

		// couple false trap: run on, squash when the second is in N3
		if (s_r.coupleCnt != 4'h0) begin
			s_nxt.coupleCnt = s_r.coupleCnt - 4'h1;
			if (s_r.coupleCnt == COUPLE_SQUASH_AT) begin
				s_nxt.squash = 1'b1;
			end
		end else if (coupleDetect) begin
			s_nxt.coupleCnt = COUPLE_CYCLES;
		end

		// i-cache miss refill; buffered instructions keep draining
		if (s_r.icMissCnt != 3'h0) begin
			s_nxt.icMissCnt = s_r.icMissCnt - 3'h1;
		end else if (icMissHit) begin
			s_nxt.icMissCnt = ICMISS_CYCLES;
		end

		// occupancy: fill and drain are independent
		s_nxt.bufCount = s_r.bufCount - BUF_CNT_W'(grpN);
		if (fillReady) begin
			s_nxt.bufCount = s_nxt.bufCount + BUF_CNT_W'(fillCount);
		end

		// grouping history for the next cycle
		if (s_r.penaltyCnt == 3'h0 && s_r.coupleCnt == 4'h0) begin
			s_nxt.fmovSep = grpFmov;
			if (grpLoneMov) begin
				s_nxt.movPend = 1'b1;
			end else if (grpN != 3'h0 || s_r.fmovSep ||
				(s_r.movPend && slotUsesMovDst[0])) begin
				s_nxt.movPend = 1'b0; // bubble spent or no consumer
			end
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs; handshakes and issueCount combinational, other data from flops
	assign fetchReady = (s_r.tState == T_IDLE);
	assign xlatValid = s_r.xlatValid;
	assign xlatPpn = s_r.xlatPpn;
	assign ittMissTrap = s_r.missTrap;
	assign predState = predRd;
	assign predTaken = predRd[1];
	assign nextLine = nextRd[NEXT_W-1:WAY_W];
	assign nextWay = nextRd[WAY_W-1:0];
	assign nextFieldStale = (s_r.lostCnt != 2'h0);
	assign mispredict = (s_r.penaltyCnt != 3'h0);
	// room for a full fetch; stalled while the i-cache refills from the e-cache
	assign fillReady = (s_r.icMissCnt == 3'h0) &&
		(s_r.bufCount <= BUF_CNT_W'(BUF_DEPTH - 4));
	assign icRefillBusy = (s_r.icMissCnt != 3'h0);
	assign bufCount = s_r.bufCount;
	assign issueCount = grpN;
	assign falseTrapBusy = (s_r.coupleCnt != 4'h0);
	assign squashRestart = s_r.squash;
endmodule : fetch_branch_predict_control

// >>> verilog/pred_ram.sv
// small synchronous memory, one write port and one registered read port
// assumes write and read may hit one address; read returns the old word
`timescale 1ns/10ps
module pred_ram #(
	parameter int W = 2, // word width
	parameter int A = 10 // address width
) (
	input wire logic clk, // core clock
	input wire logic rst_n, // async reset, clears the read register
	input wire logic we, // write strobe
	input wire logic [A-1:0] wAddr, // write address
	input wire logic [W-1:0] wData, // write data
	input wire logic [A-1:0] rAddr, // read address, sampled each cycle
	output logic [W-1:0] rData // read data, one cycle after the address
);
	logic [W-1:0] mem [0:(1<<A)-1]; // storage, no reset to stay a ram
	logic [W-1:0] rData_r; // read register

	// storage write
	always_ff @(posedge clk) begin
		if (we) begin
			mem[wAddr] <= wData;
		end
	end

	// registered read, cleared so outputs are defined from reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rData_r <= '0;
		end else begin
			rData_r <= mem[rAddr];
		end
	end

	assign rData = rData_r;
endmodule : pred_ram

// >>> verilog/pred_step.sv
// next state of one two-bit branch predictor entry
// assumes the caller only applies it to a resolved branch
`timescale 1ns/10ps
module pred_step
	import fetch_ctl_pkg::*;
(
	input wire logic [1:0] cur, // present state
	input wire logic taken, // actual outcome
	output logic [1:0] nxt // state after the outcome
);
	// one step toward the outcome, held at either end
	always_comb begin
		nxt = cur;
		if (taken && cur != PR_STRONG_TAKEN) begin
			nxt = cur + 2'h1;
		end else if (!taken && cur != PR_STRONG_NOT) begin
			nxt = cur - 2'h1;
		end
	end
endmodule : pred_step
